/* File: rtl/aaau_top.v */
// auxiliary address register file and address arithmetic unit
// assumes a core decoder driving the step/load/compare ports on CORE_CLK_I
// and an apb master on the same clock for register access
//
// Notes on behaviour
// - eight address registers, 3-bit pointer selects
// - load registers/pointer; store or pass out
// - step current register while it addresses memory
// - step in decode, core write in execute
// - add/subtract unsigned 16-bit index register
// - increment, decrement or hold current register
// - add/subtract 8-bit instruction immediate
// - bit-reversed mode carries from msb downward
// - compare with limit, set or clear test_flag
// - at wrap end, reload wrap start instead
// - end detected only by exact equality
// - before split enable, register 0 load copies
// - index/limit directly writable; mapped writes one
// - all arithmetic 16-bit unsigned
// - branch on nonzero register as loop counter
// - saved pointer stores active pointer on call
// - buffer control field layout, enable active high
// - reset clears both buffer enables
`timescale 1ns/1ps
`include "aaau_defines.vh"

module aaau_top #(
   parameter DW = 16,
   parameter NREG = 8
) (
   // clock and reset
   input wire CORE_CLK_I,
   input wire RST_I,
   // decode-stage stepping
   input wire STEP_EN_I,
   input wire [3:0] STEP_OP_I,
   input wire [15:0] INSTR_REG_I,
   input wire PTR_LOAD_EN_I,
   input wire [2:0] PTR_LOAD_I,
   // compare and branch
   input wire CMP_EN_I,
   input wire [1:0] CMP_COND_I,
   input wire BRANCH_TEST_EN_I,
   // execute-stage load from memory, accumulator, product or immediate
   input wire LOAD_EN_I,
   input wire [1:0] LOAD_DST_I,
   input wire [2:0] LOAD_REG_I,
   input wire [DW-1:0] LOAD_DATA_I,
   input wire LOAD_IS_LAR_I,
   // subroutine pointer save/restore
   input wire CALL_I,
   input wire RETURN_I,
   // read-out for store / main alu
   input wire [2:0] RD_REG_I,
   // apb slave
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output reg PREADY,
   output reg PSLVERR,
   // outputs to core
   output reg [DW-1:0] MEM_ADDR_O,
   output reg [DW-1:0] RD_DATA_O,
   output reg TEST_FLAG_O,
   output reg BRANCH_TAKE_O,
   output reg [2:0] ACTIVE_PTR_O,
   output reg [2:0] SAVED_PTR_O
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   reg [DW-1:0] address_regs_q [0:NREG-1];
   reg [2:0] active_pointer_q;
   reg [2:0] saved_pointer_q;
   reg [DW-1:0] index_step_q;
   reg [DW-1:0] compare_limit_q;
   reg [DW-1:0] wstart1_q, wend1_q, wstart2_q, wend2_q;
   reg [7:0] bufctl_q;
   reg split_enable_q;
   reg test_flag_q;
   integer i;

   // ----------------------------------------------------------------
   // arithmetic helpers
   // ----------------------------------------------------------------
   function [15:0] rev16;
      input [15:0] v;
      integer k;
      begin
         for (k = 0; k < 16; k = k + 1) begin
            rev16[k] = v[15-k];
         end
      end
   endfunction

   // reversed-carry add/sub: operate on mirrored operands
   function [15:0] rc_step;
      input [15:0] a;
      input [15:0] b;
      input sub;
      begin
         if (sub) begin
            rc_step = rev16(rev16(a) - rev16(b));
         end else begin
            rc_step = rev16(rev16(a) + rev16(b));
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // current register and step result
   // ----------------------------------------------------------------
   wire [DW-1:0] cur = address_regs_q[active_pointer_q];
   wire [15:0] imm8 = {8'h00, INSTR_REG_I[`AAAU_IMM_MSB:0]};
   reg [15:0] step_d;

   always @* begin
      // 16-bit truncation gives modulo wrap with no flag
      case (STEP_OP_I)
         `AAAU_STEP_INC: step_d = cur + `AAAU_ONE;
         `AAAU_STEP_DEC: step_d = cur - `AAAU_ONE;
         `AAAU_STEP_ADDX: step_d = cur + index_step_q;
         `AAAU_STEP_SUBX: step_d = cur - index_step_q;
         `AAAU_STEP_ADDK: step_d = cur + imm8;
         `AAAU_STEP_SUBK: step_d = cur - imm8;
         `AAAU_STEP_ADDBR: step_d = rc_step(cur, index_step_q, 1'b0);
         `AAAU_STEP_SUBBR: step_d = rc_step(cur, index_step_q, 1'b1);
         default: step_d = cur;
      endcase
   end

   // circular buffer end test, made on the value before the update
   function buf_hit;
      input enable;
      input [2:0] sel;
      input [2:0] ptr;
      input [15:0] value;
      input [15:0] end_addr;
      begin
         buf_hit = enable && (sel == ptr) && (value == end_addr);
      end
   endfunction

   wire buf1_hit = buf_hit(bufctl_q[`AAAU_BUF1_EN], bufctl_q[`AAAU_BUF1_SEL],
                           active_pointer_q, cur, wend1_q);
   wire buf2_hit = buf_hit(bufctl_q[`AAAU_BUF2_EN], bufctl_q[`AAAU_BUF2_SEL],
                           active_pointer_q, cur, wend2_q);
   wire step_mod = STEP_EN_I && (STEP_OP_I != `AAAU_STEP_NONE);
   wire [15:0] next_cur = buf1_hit ? wstart1_q : (buf2_hit ? wstart2_q : step_d);

   // compare condition
   reg cmp_true;
   always @* begin
      case (CMP_COND_I)
         `AAAU_CMP_EQ: cmp_true = (cur == compare_limit_q);
         `AAAU_CMP_LT: cmp_true = (cur < compare_limit_q);
         `AAAU_CMP_GT: cmp_true = (cur > compare_limit_q);
         default: cmp_true = (cur != compare_limit_q);
      endcase
   end

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   wire apb_acc = PSEL && PENABLE;
   // a write lands at the edge where the master samples ready high
   wire apb_wr = apb_acc && PREADY && PWRITE;
   wire is_ar = (PADDR[11:5] == `AAAU_AR_PAGE) && (PADDR[1:0] == 2'h0);
   wire [2:0] apb_ar = PADDR[4:2];
   reg apb_hit;
   reg [31:0] rdata;

   always @* begin
      apb_hit = 1'b1;
      rdata = 32'h00000000;
      if (is_ar) begin
         rdata = {16'h0000, address_regs_q[apb_ar]};
      end else begin
         case (PADDR)
            `AAAU_ADDR_INDEX: rdata = {16'h0000, index_step_q};
            `AAAU_ADDR_LIMIT: rdata = {16'h0000, compare_limit_q};
            `AAAU_ADDR_WSTART1: rdata = {16'h0000, wstart1_q};
            `AAAU_ADDR_WEND1: rdata = {16'h0000, wend1_q};
            `AAAU_ADDR_WSTART2: rdata = {16'h0000, wstart2_q};
            `AAAU_ADDR_WEND2: rdata = {16'h0000, wend2_q};
            `AAAU_ADDR_BUFCTL: rdata = {24'h000000, bufctl_q};
            `AAAU_ADDR_PTR: rdata = {26'h0000000, saved_pointer_q, active_pointer_q};
            `AAAU_ADDR_MODE: rdata = {31'h00000000, split_enable_q};
            `AAAU_ADDR_STATUS: rdata = {31'h00000000, test_flag_q};
            default: apb_hit = 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // write strobes
   // ----------------------------------------------------------------
   // core loads from memory, accumulator, product or immediate
   wire ld_ar = LOAD_EN_I && (LOAD_DST_I == `AAAU_LD_AR);
   wire ld_ptr = LOAD_EN_I && (LOAD_DST_I == `AAAU_LD_PTR);
   wire ld_index = LOAD_EN_I && (LOAD_DST_I == `AAAU_LD_INDEX);
   wire ld_limit = LOAD_EN_I && (LOAD_DST_I == `AAAU_LD_LIMIT);
   // before the split is enabled, a register 0 load also feeds index and limit
   wire lar_copy = ld_ar && LOAD_IS_LAR_I && !split_enable_q && (LOAD_REG_I == `AAAU_LAR_REG);
   // mapped writes touch only the addressed register
   wire wr_ar = apb_wr && is_ar;
   wire wr_index = apb_wr && (PADDR == `AAAU_ADDR_INDEX);
   wire wr_limit = apb_wr && (PADDR == `AAAU_ADDR_LIMIT);
   wire wr_wstart1 = apb_wr && (PADDR == `AAAU_ADDR_WSTART1);
   wire wr_wend1 = apb_wr && (PADDR == `AAAU_ADDR_WEND1);
   wire wr_wstart2 = apb_wr && (PADDR == `AAAU_ADDR_WSTART2);
   wire wr_wend2 = apb_wr && (PADDR == `AAAU_ADDR_WEND2);
   wire wr_bufctl = apb_wr && (PADDR == `AAAU_ADDR_BUFCTL);
   wire wr_ptr = apb_wr && (PADDR == `AAAU_ADDR_PTR);
   wire wr_mode = apb_wr && (PADDR == `AAAU_ADDR_MODE);
   wire wr_status = apb_wr && (PADDR == `AAAU_ADDR_STATUS);

   // ----------------------------------------------------------------
   // address registers
   // ----------------------------------------------------------------
   always @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         for (i = 0; i < NREG; i = i + 1) begin
            address_regs_q[i] <= `AAAU_ZERO16;
         end
      end else begin
         // decode-stage step of the current register
         if (step_mod) begin
            address_regs_q[active_pointer_q] <= next_cur;
         end
         // execute-stage writes follow and win over a same-cycle step
         if (ld_ar) begin
            address_regs_q[LOAD_REG_I] <= LOAD_DATA_I;
         end
         if (wr_ar) begin
            address_regs_q[apb_ar] <= PWDATA[15:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // index and limit registers
   // ----------------------------------------------------------------
   always @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         index_step_q <= `AAAU_ZERO16;
         compare_limit_q <= `AAAU_ZERO16;
      end else begin
         if (lar_copy) begin
            index_step_q <= LOAD_DATA_I;
            compare_limit_q <= LOAD_DATA_I;
         end
         if (ld_index) begin
            index_step_q <= LOAD_DATA_I;
         end
         if (ld_limit) begin
            compare_limit_q <= LOAD_DATA_I;
         end
         if (wr_index) begin
            index_step_q <= PWDATA[15:0];
         end
         if (wr_limit) begin
            compare_limit_q <= PWDATA[15:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // pointers
   // ----------------------------------------------------------------
   always @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         active_pointer_q <= 3'h0;
         saved_pointer_q <= 3'h0;
      end else begin
         if (ld_ptr) begin
            active_pointer_q <= LOAD_DATA_I[2:0];
         end
         if (PTR_LOAD_EN_I) begin
            active_pointer_q <= PTR_LOAD_I;
         end
         if (CALL_I) begin
            saved_pointer_q <= active_pointer_q;
         end else if (RETURN_I) begin
            active_pointer_q <= saved_pointer_q;
         end
         if (wr_ptr) begin
            active_pointer_q <= PWDATA[2:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // circular buffer registers
   // ----------------------------------------------------------------
   always @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         wstart1_q <= `AAAU_ZERO16;
         wend1_q <= `AAAU_ZERO16;
         wstart2_q <= `AAAU_ZERO16;
         wend2_q <= `AAAU_ZERO16;
         bufctl_q <= `AAAU_BUFCTL_RST;
      end else begin
         if (wr_wstart1) begin
            wstart1_q <= PWDATA[15:0];
         end
         if (wr_wend1) begin
            wend1_q <= PWDATA[15:0];
         end
         if (wr_wstart2) begin
            wstart2_q <= PWDATA[15:0];
         end
         if (wr_wend2) begin
            wend2_q <= PWDATA[15:0];
         end
         if (wr_bufctl) begin
            bufctl_q <= PWDATA[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // mode and test flag
   // ----------------------------------------------------------------
   always @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         split_enable_q <= 1'b0;
         test_flag_q <= 1'b0;
      end else begin
         if (wr_mode) begin
            split_enable_q <= PWDATA[0];
         end
         if (wr_status) begin
            test_flag_q <= PWDATA[0];
         end
         // a compare in the same cycle as a status write wins
         if (CMP_EN_I) begin
            test_flag_q <= cmp_true;
         end
      end
   end

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   always @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         PRDATA <= 32'h00000000;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         MEM_ADDR_O <= `AAAU_ZERO16;
         RD_DATA_O <= `AAAU_ZERO16;
         TEST_FLAG_O <= 1'b0;
         BRANCH_TAKE_O <= 1'b0;
         ACTIVE_PTR_O <= 3'h0;
         SAVED_PTR_O <= 3'h0;
      end else begin
         // one wait state: ready in the second cycle after the setup-to-access edge
         PREADY <= PSEL && PENABLE && !PREADY;
         PSLVERR <= PSEL && PENABLE && !PREADY && !apb_hit;
         PRDATA <= (PSEL && PENABLE && !PREADY && !PWRITE) ? rdata : 32'h00000000;
         MEM_ADDR_O <= cur;
         RD_DATA_O <= address_regs_q[RD_REG_I];
         TEST_FLAG_O <= test_flag_q;
         BRANCH_TAKE_O <= BRANCH_TEST_EN_I && (cur != `AAAU_ZERO16);
         ACTIVE_PTR_O <= active_pointer_q;
         SAVED_PTR_O <= saved_pointer_q;
      end
   end

endmodule

/* File: rtl/aaau_defines.vh */
// constants for the auxiliary address arithmetic unit
// assumes inclusion by rtl/aaau_top.v only
`ifndef AAAU_DEFINES_VH
`define AAAU_DEFINES_VH

// ----------------------------------------------------------------
// register byte addresses (apb)
// ----------------------------------------------------------------
`define AAAU_ADDR_AR0 12'h000
`define AAAU_ADDR_INDEX 12'h020
`define AAAU_ADDR_LIMIT 12'h024
`define AAAU_ADDR_WSTART1 12'h028
`define AAAU_ADDR_WEND1 12'h02c
`define AAAU_ADDR_WSTART2 12'h030
`define AAAU_ADDR_WEND2 12'h034
`define AAAU_ADDR_BUFCTL 12'h038
`define AAAU_ADDR_PTR 12'h03c
`define AAAU_ADDR_MODE 12'h040
`define AAAU_ADDR_STATUS 12'h044
// upper address bits shared by the eight address registers
`define AAAU_AR_PAGE 7'h00

// ----------------------------------------------------------------
// buffer control fields
// ----------------------------------------------------------------
`define AAAU_BUF1_SEL 2:0
`define AAAU_BUF1_EN 3
`define AAAU_BUF2_SEL 6:4
`define AAAU_BUF2_EN 7
`define AAAU_BUFCTL_RST 8'h00

// ----------------------------------------------------------------
// step operation codes
// ----------------------------------------------------------------
`define AAAU_STEP_NONE 4'h0
`define AAAU_STEP_INC 4'h1
`define AAAU_STEP_DEC 4'h2
`define AAAU_STEP_ADDX 4'h3
`define AAAU_STEP_SUBX 4'h4
`define AAAU_STEP_ADDK 4'h5
`define AAAU_STEP_SUBK 4'h6
`define AAAU_STEP_ADDBR 4'h7
`define AAAU_STEP_SUBBR 4'h8

// compare conditions
`define AAAU_CMP_EQ 2'h0
`define AAAU_CMP_LT 2'h1
`define AAAU_CMP_GT 2'h2
`define AAAU_CMP_NE 2'h3

// load destinations for the core load port
`define AAAU_LD_AR 2'h0
`define AAAU_LD_PTR 2'h1
`define AAAU_LD_INDEX 2'h2
`define AAAU_LD_LIMIT 2'h3
// register whose load also feeds index and limit before the split
`define AAAU_LAR_REG 3'h0

`define AAAU_ONE 16'h0001
`define AAAU_ZERO16 16'h0000
`define AAAU_IMM_MSB 7
`endif

/* File: verification/aaau_core_model.sv */
// stand-in for the core decoder and main alu: one request per call, one clock long
// assumes the bench calls issue from a single process on clk_i
`timescale 1ns/1ps
module aaau_core_model (
   // clock
   input wire clk_i,
   // one-hot request kind: step, pointer, compare, branch, load, call, return
   output reg [6:0] en_o,
   // request fields
   output reg [15:0] a_o,
   output reg [15:0] b_o
);
   initial begin
      en_o = 7'h00;
      a_o = 16'h0000;
      b_o = 16'h0000;
   end
   task issue(input [2:0] kind, input [15:0] a, input [15:0] b);
      begin
         @(posedge clk_i);
         en_o <= 7'h01 << kind;
         a_o <= a;
         b_o <= b;
         @(posedge clk_i);
         en_o <= 7'h00;
         a_o <= ~a;
         b_o <= ~b;
         // no address use of a freshly loaded register for two slots
         if (kind == 3'h4) begin
            repeat (2) @(posedge clk_i);
         end
      end
   endtask
endmodule

/* File: verification/aaau_monitor.sv */
// port checker for the address unit: apb answer, stepping, pointers, branch test
// assumes the ports of aaau_top only; bound at the foot of this file
`timescale 1ns/1ps
module aaau_monitor (
   input wire CORE_CLK_I,
   input wire RST_I,
   input wire STEP_EN_I,
   input wire [3:0] STEP_OP_I,
   input wire [15:0] INSTR_REG_I,
   input wire PTR_LOAD_EN_I,
   input wire [2:0] PTR_LOAD_I,
   input wire BRANCH_TEST_EN_I,
   input wire LOAD_EN_I,
   input wire CALL_I,
   input wire RETURN_I,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   input wire PREADY,
   input wire [15:0] MEM_ADDR_O,
   input wire BRANCH_TAKE_O,
   input wire [2:0] ACTIVE_PTR_O,
   input wire [2:0] SAVED_PTR_O
);
   reg [7:0] cb_q;
   // quiet: nothing else touches the current register and no buffer wraps
   wire q = !PSEL && !LOAD_EN_I && !PTR_LOAD_EN_I && !RETURN_I && cb_q[3] == 1'b0 && cb_q[7] == 1'b0;
   always @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I)
         cb_q <= 8'h00;
      else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h038)
         cb_q <= PWDATA[7:0];
   end
   default clocking dc @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   property p_ready;
      PSEL && PENABLE && !PREADY |=> PREADY;
   endproperty
   a_ready: assert property (p_ready) else $error("apb access not answered");
   property p_inc;
      q && STEP_EN_I && STEP_OP_I == 4'h1 |=> ##1 MEM_ADDR_O == $past(MEM_ADDR_O) + 16'h0001;
   endproperty
   a_inc: assert property (p_inc) else $error("increment wrong");
   property p_dec;
      q && STEP_EN_I && STEP_OP_I == 4'h2 |=> ##1 MEM_ADDR_O == $past(MEM_ADDR_O) - 16'h0001;
   endproperty
   a_dec: assert property (p_dec) else $error("decrement wrong");
   property p_hold;
      q && STEP_EN_I && STEP_OP_I == 4'h0 |=> ##1 $stable(MEM_ADDR_O);
   endproperty
   a_hold: assert property (p_hold) else $error("hold changed register");
   property p_addk;
      q && STEP_EN_I && STEP_OP_I == 4'h5 |=> ##1 MEM_ADDR_O == $past(MEM_ADDR_O) + {8'h00, $past(INSTR_REG_I[7:0], 2)};
   endproperty
   a_addk: assert property (p_addk) else $error("immediate add wrong");
   property p_ptr;
      PTR_LOAD_EN_I && !PSEL && !RETURN_I |=> ##1 ACTIVE_PTR_O == $past(PTR_LOAD_I, 2);
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer load wrong");
   property p_call;
      CALL_I && !PSEL |=> ##1 SAVED_PTR_O == $past(ACTIVE_PTR_O);
   endproperty
   a_call: assert property (p_call) else $error("pointer not saved");
   property p_branch;
      BRANCH_TEST_EN_I && q |=> BRANCH_TAKE_O == (MEM_ADDR_O != 16'h0000);
   endproperty
   a_branch: assert property (p_branch) else $error("branch test wrong");
   c_brev: cover property (q && STEP_EN_I && STEP_OP_I == 4'h7);
   c_call: cover property (CALL_I);
   c_wr: cover property (PREADY && PWRITE);
endmodule
bind aaau_top aaau_monitor mon (.CORE_CLK_I, .RST_I, .STEP_EN_I, .STEP_OP_I, .INSTR_REG_I, .PTR_LOAD_EN_I,
   .PTR_LOAD_I, .BRANCH_TEST_EN_I, .LOAD_EN_I, .CALL_I, .RETURN_I, .PSEL, .PENABLE, .PWRITE, .PADDR,
   .PWDATA, .PREADY, .MEM_ADDR_O, .BRANCH_TAKE_O, .ACTIVE_PTR_O, .SAVED_PTR_O);

/* File: verification/tb_aux_address_arith_unit.sv */
// bench for the address unit: apb registers, stepping, buffers, compare, pointers
// assumes aaau_core_model drives the core ports and the checker is bound
`timescale 1ns/1ps
module tb_aux_address_arith_unit;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg psel = 1'b0;
   reg pen = 1'b0;
   reg pwr = 1'b0;
   reg [11:0] pa = 12'h000;
   reg [31:0] pwd = 32'h00000000;
   reg [2:0] rsel = 3'h0;
   reg [31:0] rd;
   reg er;
   reg [15:0] v, x, k;
   reg [3:0] op;
   reg [2:0] r;
   wire [6:0] en;
   wire [15:0] a, b, rdo;
   wire [31:0] prd;
   wire prdy, perr;
   wire tfo;
   integer fails = 0;
   integer cmp_count = 0;
   integer cyc = 0;
   integer i;
   initial forever #5 clk = ~clk;
   aaau_top dut (.CORE_CLK_I(clk), .RST_I(rst), .STEP_EN_I(en[0]), .STEP_OP_I(a[3:0]), .INSTR_REG_I(b),
      .PTR_LOAD_EN_I(en[1]), .PTR_LOAD_I(a[2:0]), .CMP_EN_I(en[2]), .CMP_COND_I(a[1:0]),
      .BRANCH_TEST_EN_I(en[3]), .LOAD_EN_I(en[4]), .LOAD_DST_I(a[1:0]), .LOAD_REG_I(a[4:2]),
      .LOAD_DATA_I(b), .LOAD_IS_LAR_I(a[5]), .CALL_I(en[5]), .RETURN_I(en[6]), .RD_REG_I(rsel),
      .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
      .PSLVERR(perr), .MEM_ADDR_O(), .RD_DATA_O(rdo), .TEST_FLAG_O(tfo), .BRANCH_TAKE_O(),
      .ACTIVE_PTR_O(), .SAVED_PTR_O());
   aaau_core_model core (.clk_i(clk), .en_o(en), .a_o(a), .b_o(b));
   function [15:0] rv(input [15:0] d);
      integer n;
      for (n = 0; n < 16; n = n + 1)
         rv[n] = d[15 - n];
   endfunction
   function [15:0] f_step(input [3:0] o, input [15:0] s, input [15:0] ix, input [15:0] im);
      case (o)
         4'h1: f_step = s + 16'h0001;
         4'h2: f_step = s - 16'h0001;
         4'h3: f_step = s + ix;
         4'h4: f_step = s - ix;
         4'h5: f_step = s + {8'h00, im[7:0]};
         4'h6: f_step = s - {8'h00, im[7:0]};
         4'h7: f_step = rv(rv(s) + rv(ix));
         4'h8: f_step = rv(rv(s) - rv(ix));
         default: f_step = s;
      endcase
   endfunction
   function f_cmp(input [1:0] c, input [15:0] s, input [15:0] l);
      case (c)
         2'h0: f_cmp = s == l;
         2'h1: f_cmp = s < l;
         2'h2: f_cmp = s > l;
         default: f_cmp = s != l;
      endcase
   endfunction
   task chk(input string nm, input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task apb(input w, input [11:0] ad, input [31:0] d);
      begin
         @(posedge clk);
         psel <= 1'b1;
         pwr <= w;
         pa <= ad;
         pwd <= d;
         @(posedge clk);
         pen <= 1'b1;
         @(posedge clk);
         while (prdy !== 1'b1) begin
            @(posedge clk);
         end
         rd = prd;
         er = perr;
         psel <= 1'b0;
         pen <= 1'b0;
         pwd <= ~d;
      end
   endtask
   task test_done;
      begin
         $display("checks %0d mismatches %0d", cmp_count, fails);
         if (fails == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails = fails + 1;
         test_done;
      end
   end
   initial begin
      v = $urandom(27);
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, 12'h038, 32'h0);
      chk("bufctl", rd, 32'h0);
      apb(1'b0, 12'h100, 32'h0);
      chk("slverr", {31'h0, er}, 32'h1);
      $display("reset test done");
      for (i = 0; i < 18; i = i + 1) begin
         op = i % 9;
         r = $urandom;
         v = $urandom;
         x = $urandom;
         k = $urandom;
         if (i == 10)
            v = 16'hffff;
         apb(1'b1, 12'h020, {16'h0, x});
         apb(1'b1, {7'h0, r, 2'h0}, {16'h0, v});
         apb(1'b1, 12'h03c, {29'h0, r});
         core.issue(3'h0, {12'h0, op}, k);
         rsel <= r;
         apb(1'b0, {7'h0, r, 2'h0}, 32'h0);
         chk("step", rd, {16'h0, f_step(op, v, x, k)});
         chk("rdport", {16'h0, rdo}, {16'h0, f_step(op, v, x, k)});
      end
      $display("step test done");
      // start and end set, register at the end address, then enable; distinct registers 3 and 5
      apb(1'b1, 12'h028, 32'h100);
      apb(1'b1, 12'h02c, 32'h105);
      apb(1'b1, 12'h030, 32'h200);
      apb(1'b1, 12'h034, 32'h1f0);
      apb(1'b1, 12'h00c, 32'h105);
      apb(1'b1, 12'h014, 32'h1f0);
      apb(1'b1, 12'h038, 32'hdb);
      apb(1'b0, 12'h038, 32'h0);
      chk("bufctl", rd, 32'hdb);
      apb(1'b1, 12'h03c, 32'h3);
      core.issue(3'h0, 16'h1, 16'h0);
      apb(1'b0, 12'h00c, 32'h0);
      chk("wrap1", rd, 32'h100);
      apb(1'b1, 12'h03c, 32'h5);
      core.issue(3'h0, 16'h2, 16'h0);
      apb(1'b0, 12'h014, 32'h0);
      chk("wrap2", rd, 32'h200);
      apb(1'b1, 12'h020, 32'h2);
      apb(1'b1, 12'h014, 32'h1f1);
      core.issue(3'h0, 16'h4, 16'h0);
      apb(1'b0, 12'h014, 32'h0);
      chk("overstep", rd, 32'h1ef);
      apb(1'b1, 12'h038, 32'h0);
      $display("buffer test done");
      for (i = 0; i < 12; i = i + 1) begin
         k = 16'h01ee + i / 4;
         apb(1'b1, 12'h024, {16'h0, k});
         core.issue(3'h2, {14'h0, i[1:0]}, 16'h0);
         apb(1'b0, 12'h044, 32'h0);
         chk("flag", {31'h0, rd[0]}, {31'h0, f_cmp(i[1:0], 16'h01ef, k)});
         chk("flagport", {31'h0, tfo}, {31'h0, f_cmp(i[1:0], 16'h01ef, k)});
      end
      core.issue(3'h4, 16'h0020, 16'h1234);
      apb(1'b0, 12'h024, 32'h0);
      chk("lar_limit", rd, 32'h1234);
      apb(1'b1, 12'h024, 32'h77);
      apb(1'b0, 12'h020, 32'h0);
      chk("lar_index", rd, 32'h1234);
      apb(1'b1, 12'h040, 32'h1);
      core.issue(3'h4, 16'h0020, 16'h4321);
      apb(1'b0, 12'h020, 32'h0);
      chk("split", rd, 32'h1234);
      apb(1'b0, 12'h000, 32'h0);
      chk("ar0", rd, 32'h4321);
      $display("compare and load test done");
      r = $urandom;
      core.issue(3'h1, {13'h0, r}, 16'h0);
      core.issue(3'h5, 16'h0, 16'h0);
      core.issue(3'h3, 16'h0, 16'h0);
      core.issue(3'h1, {13'h0, ~r}, 16'h0);
      apb(1'b0, 12'h03c, 32'h0);
      chk("saved", {29'h0, rd[5:3]}, {29'h0, r});
      core.issue(3'h6, 16'h0, 16'h0);
      apb(1'b0, 12'h03c, 32'h0);
      chk("restored", {29'h0, rd[2:0]}, {29'h0, r});
      $display("pointer test done");
      test_done;
   end
endmodule
